// >>> tpg_pkg.sv
package tpg_pkg;

	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int unsigned CLK_HZ         = 20_000_000;
	localparam int unsigned ENA_TIMEOUT_MS = 100;
	localparam int unsigned ENA_TIMEOUT_CYC = (ENA_TIMEOUT_MS * (CLK_HZ / 1000));

	// ************************************************************
	// register map (byte addresses)
	// ************************************************************
	localparam logic [7:0] REG_PHASE_CTRL = 8'h00;
	localparam logic [7:0] REG_DRIVE_CFG  = 8'h04;
	localparam logic [7:0] REG_STATUS     = 8'h08;

	// phase control fields: high-side bits low, low-side bits above
	localparam int unsigned PHASES        = 3;
	localparam int unsigned CTRL_HI_LSB   = 0;
	localparam int unsigned CTRL_LO_LSB   = 3;
	localparam logic [5:0]  CTRL_RESET    = 6'h00;

	// drive config fields
	localparam int unsigned CFG_WD_MODE   = 0;
	localparam logic [0:0]  CFG_RESET     = 1'h0;

	// status fields
	localparam int unsigned ST_PIN_HI_LSB = 0;
	localparam int unsigned ST_PIN_LO_LSB = 3;
	localparam int unsigned ST_GATE_HI_LSB = 6;
	localparam int unsigned ST_GATE_LO_LSB = 9;
	localparam int unsigned ST_ENA_PIN    = 12;
	localparam int unsigned ST_DRIVE_EN   = 13;
	localparam int unsigned ST_WD_EXPIRED = 14;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic [2:0] hi;
		logic [2:0] lo;
	} tpg_req_t;

	typedef struct packed {
		logic [2:0] hi;
		logic [2:0] lo;
	} tpg_gate_t;

endpackage

// >>> tpg_gate_cmd.sv
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ns

// Functional notes
// - each internal request is the OR of its input pin and control bit
// - only high requested: high gate on, low off; only low: the reverse
// - neither or both requested: both gates low, phase node floats
// - while gate drive is disabled every gate output is held low
// - each phase decoded alone; no phase affects another
// - each of the six gates follows its own request for separate pwm, but is held off while the other request of its phase is also set
// - undriven phase inputs read as zero and request nothing; the code holds them at zero only through reset, then samples the pins
// - direct mode: enable low disables; watchdog mode: disable after enable timeout
module tpg_gate_cmd
	import tpg_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYC = ENA_TIMEOUT_CYC
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// phase input pins and enable pin
	input  wire logic [2:0]  phase_high_side_input_pin,
	input  wire logic [2:0]  phase_low_side_input_pin,
	input  wire logic        enable_pin,
	// gate commands towards the dead-time stage
	output logic [2:0]       high_side_gate_out,
	output logic [2:0]       low_side_gate_out
);

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [6:0] pin_s1_r, pin_s2_r;
	logic       ena_s3_r;

	// reset to zero so no pin requests anything until its first sample arrives
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin_s1_r <= 7'h00;
			pin_s2_r <= 7'h00;
			ena_s3_r <= 1'b0;
		end else begin
			pin_s1_r <= {enable_pin, phase_low_side_input_pin, phase_high_side_input_pin};
			pin_s2_r <= pin_s1_r;
			ena_s3_r <= pin_s2_r[6];
		end
	end

	logic [2:0] pin_hi, pin_lo;
	logic       ena_s2;
	assign pin_hi = pin_s2_r[2:0];
	assign pin_lo = pin_s2_r[5:3];
	assign ena_s2 = pin_s2_r[6];

	// ************************************************************
	// registers and apb slave
	// ************************************************************
	logic [5:0]  ctrl_r, ctrl_nxt;
	logic        wd_mode_r, wd_mode_nxt;
	logic        pready_r, pready_nxt;
	logic        pslverr_r, pslverr_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic        drive_en_r, drive_en_nxt;
	logic [21:0] wd_cnt_r, wd_cnt_nxt;
	logic        wd_expired;
	tpg_req_t    req;
	tpg_gate_t   gate;

	function automatic logic addr_mapped(input logic [7:0] a);
		return (a == REG_PHASE_CTRL) || (a == REG_DRIVE_CFG) || (a == REG_STATUS);
	endfunction

	// zero-wait slave: read data is picked up in setup, answered in access
	always_comb begin
		logic setup;
		logic access;
		setup       = psel && !penable;
		access      = psel && penable;
		ctrl_nxt    = ctrl_r;
		wd_mode_nxt = wd_mode_r;
		pready_nxt  = setup;
		pslverr_nxt = setup && !addr_mapped(paddr);
		prdata_nxt  = prdata_r;
		if (setup) begin
			prdata_nxt = 32'h0000_0000;
			unique case (paddr)
				REG_PHASE_CTRL: prdata_nxt[5:0] = ctrl_r;
				REG_DRIVE_CFG:  prdata_nxt[CFG_WD_MODE] = wd_mode_r;
				REG_STATUS: begin
					prdata_nxt[ST_PIN_HI_LSB +: PHASES]  = pin_hi;
					prdata_nxt[ST_PIN_LO_LSB +: PHASES]  = pin_lo;
					prdata_nxt[ST_GATE_HI_LSB +: PHASES] = gate.hi;
					prdata_nxt[ST_GATE_LO_LSB +: PHASES] = gate.lo;
					prdata_nxt[ST_ENA_PIN]               = ena_s2;
					prdata_nxt[ST_DRIVE_EN]              = drive_en_r;
					prdata_nxt[ST_WD_EXPIRED]            = wd_expired;
				end
				default: prdata_nxt = 32'h0000_0000;
			endcase
		end
		// writes take effect only at the completing access edge
		if (access && pready_r && pwrite) begin
			if (paddr == REG_PHASE_CTRL) begin
				ctrl_nxt = pwdata[5:0];
			end
			if (paddr == REG_DRIVE_CFG) begin
				wd_mode_nxt = pwdata[CFG_WD_MODE];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_r    <= CTRL_RESET;
			wd_mode_r <= CFG_RESET[0];
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			ctrl_r    <= ctrl_nxt;
			wd_mode_r <= wd_mode_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r  <= prdata_nxt;
		end
	end

	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign prdata  = prdata_r;

	// ************************************************************
	// enable supervision
	// ************************************************************
	assign wd_expired = (wd_cnt_r >= TIMEOUT_CYC[21:0]);

	// watchdog mode wants the enable pin to keep toggling; any edge restarts
	always_comb begin
		wd_cnt_nxt = wd_cnt_r;
		if (ena_s2 != ena_s3_r) begin
			wd_cnt_nxt = 22'h00_0000;
		end else if (!wd_expired) begin
			wd_cnt_nxt = wd_cnt_r + 22'h00_0001;
		end
		drive_en_nxt = wd_mode_r ? !wd_expired : ena_s2;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wd_cnt_r   <= 22'h00_0000;
			drive_en_r <= 1'b0;
		end else begin
			wd_cnt_r   <= wd_cnt_nxt;
			drive_en_r <= drive_en_nxt;
		end
	end

	// ************************************************************
	// request combining and gate decode
	// ************************************************************
	// gates stay combinational so pwm edges pass without a clock of delay
	always_comb begin
		req.hi = pin_hi | ctrl_r[CTRL_HI_LSB +: PHASES];
		req.lo = pin_lo | ctrl_r[CTRL_LO_LSB +: PHASES];
		for (int p = 0; p < PHASES; p++) begin
			// per-bit decode keeps phases apart, each gate from both requests of its phase
			gate.hi[p] = drive_en_r && req.hi[p] && !req.lo[p];
			gate.lo[p] = drive_en_r && req.lo[p] && !req.hi[p];
		end
	end

	assign high_side_gate_out = gate.hi;
	assign low_side_gate_out  = gate.lo;

	// ************************************************************
	// assertions
	// ************************************************************
	AST_OR_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
		req.hi == (pin_s2_r[2:0] | ctrl_r[2:0]))
		else $error("high request is not pin or bit");

	AST_OR_LOW: assert property (@(posedge clk_sys) disable iff (rst)
		!pin_s2_r[3] && !ctrl_r[3] |-> !req.lo[0])
		else $error("low request without source");

	AST_HIGH_ONLY: assert property (@(posedge clk_sys) disable iff (rst)
		drive_en_r && req.hi[1] && !req.lo[1] |-> high_side_gate_out[1] && !low_side_gate_out[1])
		else $error("high-only request not driving high gate");

	AST_LOW_ONLY: assert property (@(posedge clk_sys) disable iff (rst)
		drive_en_r && req.lo[2] && !req.hi[2] |-> low_side_gate_out[2] && !high_side_gate_out[2])
		else $error("low-only request not driving low gate");

	AST_BOTH_OFF: assert property (@(posedge clk_sys) disable iff (rst)
		((high_side_gate_out | low_side_gate_out) & ~(req.hi ^ req.lo)) == 3'h0)
		else $error("gate on with neither or both requests");

	AST_DISABLED_LOW: assert property (@(posedge clk_sys) disable iff (rst)
		!drive_en_r |-> (high_side_gate_out == 3'h0) && (low_side_gate_out == 3'h0))
		else $error("gate on while drive disabled");

	AST_PHASE_INDEP: assert property (@(posedge clk_sys) disable iff (rst)
		drive_en_r && $stable(req.hi[0]) && $stable(req.lo[0]) && $past(drive_en_r)
		|-> $stable(high_side_gate_out[0]) && $stable(low_side_gate_out[0]))
		else $error("phase a moved without own request change");

	AST_DIRECT_DISABLE: assert property (@(posedge clk_sys) disable iff (rst)
		!wd_mode_r && !ena_s2 |=> !drive_en_r)
		else $error("direct mode enable low did not disable");

	AST_WD_TIMEOUT: assert property (@(posedge clk_sys) disable iff (rst)
		wd_mode_r && wd_expired && (ena_s2 == ena_s3_r) |=> !drive_en_r)
		else $error("watchdog timeout did not disable");

	AST_NO_LATENCY: assert property (@(posedge clk_sys) disable iff (rst)
		drive_en_r && $rose(req.hi[0]) && !req.lo[0] |-> high_side_gate_out[0])
		else $error("gate lagged its request");

	AST_APB_ANSWER: assert property (@(posedge clk_sys) disable iff (rst)
		psel && !penable |=> pready ##1 !pready)
		else $error("apb answer not one cycle after setup");

endmodule

// >>> tpg_mcu_model.sv
`timescale 1ns/1ns

// ************************************************************
// controller that drives the phase pins
// ************************************************************
module tpg_mcu_model
	import tpg_pkg::*;
(
	// clock and reset
	input  wire logic     clk_sys,
	input  wire logic     rst,
	// commands from the bench
	input  wire logic     use_pins,
	input  wire tpg_req_t cmd,
	// phase pins
	output logic [2:0]    phase_high_side_input_pin,
	output logic [2:0]    phase_low_side_input_pin
);
	// pins held at zero while the register path is in charge
	always_ff @(posedge clk_sys) begin
		if (rst || !use_pins) begin
			phase_high_side_input_pin <= 3'h0;
			phase_low_side_input_pin  <= 3'h0;
		end else begin
			phase_high_side_input_pin <= cmd.hi;
			phase_low_side_input_pin  <= cmd.lo;
		end
	end
endmodule

// >>> tb_tpg_gate_cmd.sv
`timescale 1ns/1ns

module tb_tpg_gate_cmd
	import tpg_pkg::*;
;
	// ************************************************************
	// signals
	// ************************************************************
	logic clk_sys = 1'b0, rst = 1'b1, use_pins = 1'b0, enable_pin = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [2:0] hp, lp, hpin, lpin, hr, lr, ghi, glo;
	logic e;
	tpg_req_t cmd = '0;
	int err_total = 0, n_checks = 0, i;

	always #25 clk_sys = ~clk_sys;

	tpg_mcu_model tpg_mcu_model_i (.clk_sys(clk_sys), .rst(rst), .use_pins(use_pins),
		.cmd(cmd), .phase_high_side_input_pin(hpin), .phase_low_side_input_pin(lpin));
	tpg_gate_cmd #(.TIMEOUT_CYC(20)) tpg_gate_cmd_i (.clk_sys(clk_sys), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.phase_high_side_input_pin(hpin), .phase_low_side_input_pin(lpin),
		.enable_pin(enable_pin), .high_side_gate_out(ghi), .low_side_gate_out(glo));

	// ************************************************************
	// helpers
	// ************************************************************
	// expected gates {high, low} from the merged requests
	function automatic logic [5:0] dec(input logic [2:0] h, input logic [2:0] l,
		input logic en);
		return en ? {h & ~l, l & ~h} : 6'h00;
	endfunction

	// expected status word: pins idle, drive on, watchdog not expired
	function automatic logic [31:0] stat(input logic [2:0] gh, input logic [2:0] gl,
		input logic en);
		return (32'(gh) << ST_GATE_HI_LSB) | (32'(gl) << ST_GATE_LO_LSB)
			| (32'(en) << ST_ENA_PIN) | (32'h1 << ST_DRIVE_EN);
	endfunction

	task automatic chk6(input logic [5:0] got, input logic [5:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t gates %h want %h", $time, got, exp);
		end
	endtask

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t word %h want %h", $time, got, exp);
		end
	endtask

	// one apb transfer; waits for pready, bounded
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge clk_sys);
		if (k == 20) begin
			err_total++;
			$display("BAD %0t no pready", $time);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		give_verdict();
	end

	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		void'($urandom(87855));
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0; enable_pin <= 1'b1;
		apb(1'b0, REG_PHASE_CTRL, 32'h0);
		chk32(q, {26'h0, CTRL_RESET});
		chk32({31'h0, e}, 32'h0);
		apb(1'b0, 8'h0c, 32'h0); chk32({q[30:0], e}, 32'h1);
		$display("test regs done");
		// modes: pins only, register only, both merged; corners first
		for (i = 0; i < 36; i++) begin
			{hp, lp, hr, lr} = 12'($urandom);
			if (i < 2) {hp, lp, hr, lr} = i ? 12'hfff : 12'h000;
			if (i % 3 == 0) {hr, lr} = 6'h00;
			if (i % 3 == 1) {hp, lp} = 6'h00;
			@(posedge clk_sys);
			cmd <= '{hi: hp, lo: lp}; use_pins <= (i % 3 != 1);
			apb(1'b1, REG_PHASE_CTRL, {26'h0, lr, hr});
			repeat (5) @(posedge clk_sys);
			chk6({ghi, glo}, dec(hp | hr, lp | lr, 1'b1));
		end
		$display("test decode done");
		use_pins <= 1'b0;
		apb(1'b1, REG_PHASE_CTRL, 32'h0);
		repeat (5) @(posedge clk_sys);
		apb(1'b1, REG_PHASE_CTRL, 32'h2b);
		#1 chk6({ghi, glo}, dec(3'h3, 3'h5, 1'b1));
		@(posedge clk_sys);
		enable_pin <= 1'b0;
		repeat (5) @(posedge clk_sys);
		chk6({ghi, glo}, 6'h00);
		enable_pin <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk6({ghi, glo}, dec(3'h3, 3'h5, 1'b1));
		$display("test enable done");
		// watchdog mode: edges every 5 cycles keep drive, silence stops it
		apb(1'b1, REG_DRIVE_CFG, 32'h1);
		repeat (8) begin
			repeat (5) @(posedge clk_sys);
			enable_pin <= ~enable_pin;
		end
		chk6({ghi, glo}, dec(3'h3, 3'h5, 1'b1));
		repeat (40) @(posedge clk_sys);
		chk6({ghi, glo}, 6'h00);
		enable_pin <= ~enable_pin;
		repeat (5) @(posedge clk_sys);
		chk6({ghi, glo}, dec(3'h3, 3'h5, 1'b1));
		apb(1'b0, REG_DRIVE_CFG, 32'h0);
		chk32(q, 32'h1);
		apb(1'b0, REG_STATUS, 32'h0);
		chk32(q, stat(3'h2, 3'h4, enable_pin));
		$display("test watchdog done");
		// mid-run reset: drive drops, registers return to reset values
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		chk6({ghi, glo}, 6'h00);
		apb(1'b0, REG_PHASE_CTRL, 32'h0);
		chk32(q, {26'h0, CTRL_RESET});
		apb(1'b0, REG_DRIVE_CFG, 32'h0);
		chk32(q, {31'h0, CFG_RESET});
		$display("test reset done");
		give_verdict();
	end
endmodule
